// ---- hdl/mpcs_abil_if.sv ----
// carrier between the register bank and the partner ability capture
`timescale 1ns/1ps
`default_nettype none
interface mpcs_abil_if (
    input wire logic clk,
    input wire logic rstn
);
    logic        word_valid;
    logic [15:0] word;
    logic        restart;
    logic [15:0] ability;
    logic        ack_rise;

    modport bank (input clk, input rstn, output word_valid, output word, output restart,
                  input ability, input ack_rise);
    modport cap  (input clk, input rstn, input word_valid, input word, input restart,
                  output ability, output ack_rise);
endinterface
`default_nettype wire

// ---- hdl/mpcs_ability_capture.sv ----
// partner ability capture: takes a word only after three matching arrivals
`timescale 1ns/1ps
`default_nettype none
module mpcs_ability_capture
    import mpcs_pkg::*;
(
    mpcs_abil_if.cap ab
);
    typedef struct packed {
        logic [15:0] prev;
        logic [1:0]  cnt;
        logic [15:0] ability;
        logic        ack_rise;
    } mpcs_cap_t;

    mpcs_cap_t q;
    mpcs_cap_t d;

    always_comb begin
        d = q;
        d.ack_rise = 1'b0;
        if (ab.restart) begin
            d.cnt = 2'h0;
            d.ability = 16'h0000;
        end else if (ab.word_valid) begin
            if (q.cnt != 2'h0 && ab.word == q.prev) begin
                if (q.cnt < 2'(MATCH_COUNT - 1)) begin
                    d.cnt = q.cnt + 2'h1;
                end else begin
                    // third identical word: publish it with acknowledge set
                    d.ability = (ab.word & PA_KEEP_MASK) | (16'h0001 << PA_ACK);
                    d.ack_rise = ~q.ability[PA_ACK];
                end
            end else begin
                d.prev = ab.word;
                d.cnt = 2'h1;
            end
        end
    end

    always_ff @(posedge ab.clk) begin
        if (!ab.rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ab.ability  = q.ability;
    assign ab.ack_rise = q.ack_rise;

    default clocking cb @(posedge ab.clk); endclocking
    default disable iff (!ab.rstn);

    sequence s_third_match;
        ab.word_valid && !ab.restart && q.cnt == 2'h2 && ab.word == q.prev;
    endsequence

    a_ack_after_three: assert property (s_third_match |=> q.ability[PA_ACK])
        else $error("acknowledge not set after third matching word");
    a_ack_needs_count: assert property ($rose(q.ability[PA_ACK]) |-> $past(q.cnt) == 2'h2)
        else $error("acknowledge set before three matching words");
    a_reserved_clear: assert property ((q.ability & ~PA_KEEP_MASK & ~(16'h0001 << PA_ACK)) == 16'h0000)
        else $error("reserved partner ability bit set");
endmodule
`default_nettype wire

// ---- hdl/mpcs_pkg.sv ----
// constants, field positions and rate codes for the multi-rate pcs mode control registers
package mpcs_pkg;
    // register indices; byte address is four times the index
    localparam logic [10:0] IDX_IF_MODE   = 11'h014;
    localparam logic [10:0] IDX_CTRL      = 11'h400;
    localparam logic [10:0] IDX_STATUS    = 11'h401;
    localparam logic [10:0] IDX_PARTNER   = 11'h405;
    localparam logic [10:0] IDX_IRQ_STAT  = 11'h420;
    localparam logic [10:0] IDX_IRQ_CLEAR = 11'h421;
    localparam logic [10:0] IDX_IRQ_EN    = 11'h422;

    localparam int IFM_SERIAL_SEL = 0;
    localparam int IFM_USE_NEG    = 1;
    localparam int IFM_SPEED_LO   = 2;
    localparam int CTL_UNIV_SEL   = 0;
    localparam int CTL_NEG_EN     = 1;
    localparam int CTL_SPEED_LO   = 2;
    localparam int CTL_RESTART    = 9;
    localparam int STS_LINK       = 2;
    localparam int STS_AN_DONE    = 5;
    localparam int PA_CLOCK_STOP  = 7;
    localparam int PA_LOWPOWER    = 8;
    localparam int PA_SPEED_LO    = 9;
    localparam int PA_DUPLEX      = 12;
    localparam int PA_ACK         = 14;
    localparam int PA_LINK        = 15;

    localparam logic [15:0] PA_KEEP_MASK  = 16'h9F80;
    localparam logic [3:0]  IFM_RESET     = 4'h0;
    localparam logic [2:0]  CTL_SPEED_RST = 3'h0;
    localparam logic        CTL_NEG_RST   = 1'b1;
    localparam int          MATCH_COUNT   = 3;

    localparam logic [1:0] LS_10M  = 2'h0;
    localparam logic [1:0] LS_100M = 2'h1;
    localparam logic [1:0] LS_1G   = 2'h2;
    localparam logic [2:0] HS_10M  = 3'h0;
    localparam logic [2:0] HS_100M = 3'h1;
    localparam logic [2:0] HS_1G   = 3'h2;
    localparam logic [2:0] HS_10G  = 3'h3;
    localparam logic [2:0] HS_2G5  = 3'h4;
    localparam logic [2:0] HS_5G   = 3'h5;

    // interrupt status bit positions
    localparam int EV_LINK_LOST = 0;
    localparam int EV_AN_DONE   = 1;
    localparam int EV_PARTNER   = 2;
    localparam int EV_COUNT     = 3;
endpackage

// ---- hdl/mpcs_regs.sv ----
// mode control and status register bank with avalon-mm slave and interrupt
`timescale 1ns/1ps
`default_nettype none
module mpcs_regs
    import mpcs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic [12:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        LINK_SYNC,
    input  wire logic        AN_DONE,
    input  wire logic [1:0]  LS_PARTNER_SPEED,
    input  wire logic        RX_ABILITY_VALID,
    input  wire logic [15:0] RX_ABILITY,
    output logic             LOWSPEED_SERIAL_SELECT,
    output logic      [1:0]  LOWSPEED_SPEED,
    output logic             HIGHSPEED_UNIVERSAL_SELECT,
    output logic      [2:0]  HIGHSPEED_SPEED,
    output logic             AN_RESTART,
    output logic             IRQ
);
    typedef struct packed {
        logic                ack;
        logic [31:0]         rdata;
        logic                serial_sel;
        logic                use_neg;
        logic [1:0]          ls_field;
        logic                univ_sel;
        logic                neg_en;
        logic [2:0]          hs_field;
        logic                restart;
        logic                link_ll;
        logic                an_done;
        logic [EV_COUNT-1:0] irq_stat;
        logic [EV_COUNT-1:0] irq_en;
        logic [1:0]          ls_speed;
        logic [2:0]          hs_speed;
    } mpcs_state_t;

    mpcs_state_t q;
    mpcs_state_t d;
    logic [15:0] ability;
    logic        ack_rise;

    mpcs_abil_if abil (.clk(CLK), .rstn(RSTN));

    mpcs_ability_capture u_capture (
        .ab (abil.cap)
    );

    assign abil.word_valid = RX_ABILITY_VALID;
    assign abil.word       = RX_ABILITY;
    assign abil.restart    = q.restart;
    assign ability         = abil.ability;
    assign ack_rise        = abil.ack_rise;

    // byte-lane merge of a write onto the current register image
    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [10:0] idx;
    logic        req;
    logic        wr_now;
    logic        rd_now;
    logic [31:0] ifm_img;
    logic [31:0] ctl_img;
    logic [31:0] sts_img;
    logic [31:0] wimg;

    assign idx    = AVS_ADDRESS[12:2];
    assign req    = AVS_READ | AVS_WRITE;
    assign wr_now = AVS_WRITE & q.ack;
    assign rd_now = AVS_READ & q.ack;

    always_comb begin
        ifm_img = 32'h0000_0000;
        ifm_img[IFM_SERIAL_SEL] = q.serial_sel;
        ifm_img[IFM_USE_NEG] = q.use_neg;
        ifm_img[IFM_SPEED_LO +: 2] = q.ls_field;
        ctl_img = 32'h0000_0000;
        ctl_img[CTL_UNIV_SEL] = q.univ_sel;
        ctl_img[CTL_NEG_EN] = q.neg_en;
        ctl_img[CTL_SPEED_LO +: 3] = q.hs_field;
        ctl_img[CTL_RESTART] = q.restart;
        sts_img = 32'h0000_0000;
        sts_img[STS_LINK] = q.link_ll;
        sts_img[STS_AN_DONE] = q.an_done;
    end

    always_comb begin
        d = q;
        wimg = 32'h0000_0000;
        // one wait state: data are prepared in the first cycle and shown in the second
        d.ack = req & ~q.ack;
        if (req & ~q.ack) begin
            case (idx)
                IDX_IF_MODE:   d.rdata = ifm_img;
                IDX_CTRL:      d.rdata = ctl_img;
                IDX_STATUS:    d.rdata = sts_img;
                IDX_PARTNER:   d.rdata = {16'h0000, ability};
                IDX_IRQ_STAT:  d.rdata = {{(32-EV_COUNT){1'b0}}, q.irq_stat};
                IDX_IRQ_EN:    d.rdata = {{(32-EV_COUNT){1'b0}}, q.irq_en};
                default:       d.rdata = 32'h0000_0000;
            endcase
        end

        // device clears the restart request once it has been issued
        d.restart = 1'b0;
        if (wr_now) begin
            case (idx)
                IDX_IF_MODE: begin
                    wimg = merge(ifm_img, AVS_WRITEDATA, AVS_BYTEENABLE);
                    d.serial_sel = wimg[IFM_SERIAL_SEL];
                    d.use_neg = wimg[IFM_USE_NEG];
                    d.ls_field = wimg[IFM_SPEED_LO +: 2];
                end
                IDX_CTRL: begin
                    wimg = merge(ctl_img, AVS_WRITEDATA, AVS_BYTEENABLE);
                    d.univ_sel = wimg[CTL_UNIV_SEL];
                    d.neg_en = wimg[CTL_NEG_EN];
                    d.hs_field = wimg[CTL_SPEED_LO +: 3];
                    d.restart = AVS_BYTEENABLE[1] & AVS_WRITEDATA[CTL_RESTART];
                end
                IDX_IRQ_EN: begin
                    wimg = merge({{(32-EV_COUNT){1'b0}}, q.irq_en}, AVS_WRITEDATA, AVS_BYTEENABLE);
                    d.irq_en = wimg[EV_COUNT-1:0];
                end
                IDX_IRQ_CLEAR: begin
                    if (AVS_BYTEENABLE[0]) begin
                        d.irq_stat = q.irq_stat & ~AVS_WRITEDATA[EV_COUNT-1:0];
                    end
                end
                default: begin
                    d.rdata = q.rdata;
                end
            endcase
        end

        // latched-low link: reloaded only by a read of the status register
        if (rd_now && idx == IDX_STATUS) begin
            d.link_ll = LINK_SYNC;
        end
        if (!LINK_SYNC) begin
            d.link_ll = 1'b0;
        end

        // completion is forgotten on restart; a completion in the same cycle still counts
        if (q.restart) begin
            d.an_done = 1'b0;
        end
        if (AN_DONE) begin
            d.an_done = 1'b1;
        end

        // event sets win over a software clear in the same cycle
        if (q.link_ll && !LINK_SYNC) begin
            d.irq_stat[EV_LINK_LOST] = 1'b1;
        end
        if (AN_DONE) begin
            d.irq_stat[EV_AN_DONE] = 1'b1;
        end
        if (ack_rise) begin
            d.irq_stat[EV_PARTNER] = 1'b1;
        end

        // effective low-speed rate; the field is ignored unless manual sgmii
        if (!q.serial_sel) begin
            d.ls_speed = LS_1G;
        end else if (q.use_neg) begin
            d.ls_speed = LS_PARTNER_SPEED;
        end else begin
            d.ls_speed = q.ls_field;
        end

        // effective high-speed rate
        if (!q.univ_sel) begin
            d.hs_speed = HS_10G;
        end else if (q.neg_en) begin
            d.hs_speed = ability[PA_SPEED_LO +: 3];
        end else begin
            d.hs_speed = q.hs_field;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            q <= '0;
            q.serial_sel <= IFM_RESET[IFM_SERIAL_SEL];
            q.use_neg <= IFM_RESET[IFM_USE_NEG];
            q.ls_field <= IFM_RESET[IFM_SPEED_LO +: 2];
            q.neg_en <= CTL_NEG_RST;
            q.hs_field <= CTL_SPEED_RST;
            q.ls_speed <= LS_1G;
            q.hs_speed <= HS_10G;
        end else begin
            q <= d;
        end
    end

    assign AVS_WAITREQUEST            = req & ~q.ack;
    assign AVS_READDATA               = q.rdata;
    assign LOWSPEED_SERIAL_SELECT     = q.serial_sel;
    assign LOWSPEED_SPEED             = q.ls_speed;
    assign HIGHSPEED_UNIVERSAL_SELECT = q.univ_sel;
    assign HIGHSPEED_SPEED            = q.hs_speed;
    assign AN_RESTART                 = q.restart;
    assign IRQ                        = |(q.irq_stat & q.irq_en);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_req_waiting;
        req && AVS_WAITREQUEST;
    endsequence

    sequence s_restart_write;
        wr_now && idx == IDX_CTRL && AVS_BYTEENABLE[1] && AVS_WRITEDATA[CTL_RESTART];
    endsequence

    a_wait_one_cycle: assert property (s_req_waiting |=> !AVS_WAITREQUEST)
        else $error("waitrequest held longer than one cycle");
    a_restart_issued: assert property (s_restart_write |=> AN_RESTART ##1 !AN_RESTART)
        else $error("restart not issued for one cycle and cleared");
    a_unmapped_zero: assert property (req && !q.ack && idx != IDX_IF_MODE && idx != IDX_CTRL
        && idx != IDX_STATUS && idx != IDX_PARTNER && idx != IDX_IRQ_STAT && idx != IDX_IRQ_EN
        |=> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped address did not read zero");
    a_link_latch_low: assert property (!LINK_SYNC |=> !q.link_ll)
        else $error("link status not latched low after loss");
    a_link_held_low: assert property (!q.link_ll && !(rd_now && idx == IDX_STATUS) |=> !q.link_ll)
        else $error("link status recovered without a status read");
    a_an_done_set: assert property (AN_DONE |=> q.an_done)
        else $error("completion not recorded");
    a_hs_fixed_rate: assert property (!q.univ_sel |=> HIGHSPEED_SPEED == HS_10G)
        else $error("10GBASE-R mode not at 10G");
    a_hs_manual_rate: assert property (q.univ_sel && !q.neg_en |=> HIGHSPEED_SPEED == $past(q.hs_field))
        else $error("manual high-speed rate not applied");
    a_ls_field_ignored: assert property (!q.serial_sel |=> LOWSPEED_SPEED == LS_1G)
        else $error("speed field used outside sgmii");
    a_ls_manual_rate: assert property (q.serial_sel && !q.use_neg |=> LOWSPEED_SPEED == $past(q.ls_field))
        else $error("manual sgmii rate not applied");
    a_ls_negotiated: assert property (q.serial_sel && q.use_neg |=> LOWSPEED_SPEED == $past(LS_PARTNER_SPEED))
        else $error("negotiated sgmii rate not applied");
    a_irq_follows: assert property (AN_DONE && q.irq_en[EV_AN_DONE] |=> IRQ)
        else $error("enabled event did not raise interrupt");

    // writes that carry lane 0 of a mode register
    sequence s_ifm_write;
        wr_now && idx == IDX_IF_MODE && AVS_BYTEENABLE[0];
    endsequence

    sequence s_ctrl_write;
        wr_now && idx == IDX_CTRL && AVS_BYTEENABLE[0];
    endsequence

    a_serial_follows: assert property (s_ifm_write
        |=> LOWSPEED_SERIAL_SELECT == $past(AVS_WRITEDATA[IFM_SERIAL_SEL]))
        else $error("interface select did not take the written value");
    a_univ_follows: assert property (s_ctrl_write
        |=> HIGHSPEED_UNIVERSAL_SELECT == $past(AVS_WRITEDATA[CTL_UNIV_SEL]))
        else $error("high-speed select did not take the written value");
    a_hs_negotiated: assert property (q.univ_sel && q.neg_en
        |=> HIGHSPEED_SPEED == $past(ability[PA_SPEED_LO +: 3]))
        else $error("negotiated high-speed rate not applied");
    a_restart_clears: assert property (AN_RESTART |=> !AN_RESTART)
        else $error("restart request not cleared by the device");
    a_done_forgotten: assert property (q.restart && !AN_DONE |=> !q.an_done)
        else $error("completion kept across a restart");
    a_partner_read: assert property (AVS_WAITREQUEST && idx == IDX_PARTNER
        |=> AVS_READDATA == {16'h0000, $past(ability)})
        else $error("partner ability read wrong");
    // reserved bits of the mapped registers read as zero
    a_ifm_reserved: assert property (AVS_WAITREQUEST && idx == IDX_IF_MODE
        |=> AVS_READDATA[31:IFM_SPEED_LO + 2] == '0)
        else $error("reserved interface mode bit read set");
    a_sts_reserved: assert property (AVS_WAITREQUEST && idx == IDX_STATUS
        |=> (AVS_READDATA & ~((32'h0000_0001 << STS_LINK) | (32'h0000_0001 << STS_AN_DONE))) == 32'h0000_0000)
        else $error("reserved status bit read set");
    a_ctl_reserved: assert property (AVS_WAITREQUEST && idx == IDX_CTRL
        |=> (AVS_READDATA & ~((32'h0000_0007 << CTL_SPEED_LO) | (32'h0000_0001 << CTL_RESTART)
        | (32'h0000_0001 << CTL_NEG_EN) | (32'h0000_0001 << CTL_UNIV_SEL))) == 32'h0000_0000)
        else $error("reserved control bit read set");
    // read data stand between answers, so a slow master still finds them
    a_rdata_stands: assert property (!AVS_WAITREQUEST |=> $stable(AVS_READDATA))
        else $error("read data changed outside a request");
    a_done_event: assert property (AN_DONE |=> q.irq_stat[EV_AN_DONE])
        else $error("completion event lost against a clear");
    a_link_event: assert property (q.link_ll && !LINK_SYNC |=> q.irq_stat[EV_LINK_LOST])
        else $error("link loss event not recorded");
    a_irq_cleared: assert property (wr_now && idx == IDX_IRQ_CLEAR && AVS_BYTEENABLE[0]
        && AVS_WRITEDATA[EV_AN_DONE] && !AN_DONE |=> !q.irq_stat[EV_AN_DONE])
        else $error("event bit not cleared by write");
endmodule
`default_nettype wire

// ---- tb/mpcs_partner_model.sv ----
// link partner model: ability words, link sync, negotiation done and sgmii speed
`timescale 1ns/1ps
`default_nettype none
module mpcs_partner_model
    import mpcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        an_restart,
    output logic             link_sync,
    output logic             an_done,
    output logic      [1:0]  ls_speed,
    output logic             rx_valid,
    output logic      [15:0] rx_ability,
    output logic      [7:0]  n_restart
);
    initial begin
        link_sync = 1'b0;
        an_done = 1'b0;
        ls_speed = 2'h0;
        rx_valid = 1'b0;
        rx_ability = 16'h0000;
    end
    // counts cycles of restart so the bench sees the pulse width, not just its presence
    always_ff @(posedge clk) begin
        if (!rstn) begin
            n_restart <= 8'h00;
        end else if (an_restart) begin
            n_restart <= n_restart + 8'h01;
        end
    end
    task automatic send_word(input logic [15:0] w);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_ability <= w;
        @(posedge clk);
        rx_valid <= 1'b0;
        // word lines are not held once released: show the inverse so nothing is taken by luck
        rx_ability <= ~w;
    endtask
    task automatic pulse_done();
        @(posedge clk);
        an_done <= 1'b1;
        @(posedge clk);
        an_done <= 1'b0;
    endtask
    task automatic set_link(input logic v);
        @(posedge clk);
        link_sync <= v;
    endtask
    task automatic set_speed(input logic [1:0] v);
        @(posedge clk);
        ls_speed <= v;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the pcs mode control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
    import mpcs_pkg::*;
;
    localparam logic [15:0] W_A = 16'hB9FF;
    localparam logic [15:0] W_B = 16'hB7FF;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  be = 4'h0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        link_sync;
    logic        an_done;
    logic [1:0]  ls_pspd;
    logic        rx_valid;
    logic [15:0] rx_word;
    logic        ls_sel;
    logic [1:0]  ls_spd;
    logic        hs_sel;
    logic [2:0]  hs_spd;
    logic        an_restart;
    logic        irq;
    logic [7:0]  n_rst;
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [1:0]  ls_codes [3] = '{LS_10M, LS_100M, LS_1G};
    logic [2:0]  hs_codes [4] = '{HS_10M, HS_100M, HS_1G, HS_5G};
    logic [15:0] seq [4] = '{W_B, W_B, W_A, W_B};

    mpcs_regs i_dut (
        .CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .LINK_SYNC(link_sync), .AN_DONE(an_done), .LS_PARTNER_SPEED(ls_pspd),
        .RX_ABILITY_VALID(rx_valid), .RX_ABILITY(rx_word), .LOWSPEED_SERIAL_SELECT(ls_sel),
        .LOWSPEED_SPEED(ls_spd), .HIGHSPEED_UNIVERSAL_SELECT(hs_sel), .HIGHSPEED_SPEED(hs_spd),
        .AN_RESTART(an_restart), .IRQ(irq)
    );
    mpcs_partner_model i_partner (
        .clk(clk), .rstn(rstn), .an_restart(an_restart), .link_sync(link_sync), .an_done(an_done),
        .ls_speed(ls_pspd), .rx_valid(rx_valid), .rx_ability(rx_word), .n_restart(n_rst)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one access; request held until waitrequest is seen low at a rising edge
    task automatic bus_rw(input logic w, input logic [10:0] idx, input logic [31:0] d,
                          input logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        // no limit of its own here: a slave that never answers is caught by the cycle ceiling
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        `CHK(n, 2)
    endtask
    task automatic wr32(input logic [10:0] idx, input logic [31:0] d, input logic [3:0] b = 4'hF);
        logic [31:0] q;
        bus_rw(1'b1, idx, d, b, q);
    endtask
    task automatic rd_chk(input logic [10:0] idx, input logic [31:0] e);
        logic [31:0] q;
        bus_rw(1'b0, idx, 32'h0000_0000, 4'hF, q);
        `CHK(q, e)
    endtask
    // rate outputs lag their causes by one register stage
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        settle();
        `CHK(ls_spd, LS_1G)
        `CHK(hs_spd, HS_10G)
        rd_chk(IDX_IF_MODE, 32'h0000_0000);
        rd_chk(IDX_CTRL, 32'h0000_0002);
        rd_chk(IDX_STATUS, 32'h0000_0000);
        rd_chk(IDX_IRQ_EN, 32'h0000_0000);
        wr32(IDX_PARTNER, 32'hFFFF_FFFF);
        wr32(11'h402, 32'hFFFF_FFFF);
        rd_chk(IDX_PARTNER, 32'h0000_0000);
        rd_chk(11'h402, 32'h0000_0000);
        rd_chk(11'h015, 32'h0000_0000);
        wr32(IDX_IF_MODE, 32'hFFFF_FFFF);
        rd_chk(IDX_IF_MODE, 32'h0000_000F);
        i_partner.set_speed(LS_100M);
        settle();
        `CHK(ls_sel, 1'b1)
        `CHK(ls_spd, LS_100M)
        foreach (ls_codes[i]) begin
            wr32(IDX_IF_MODE, {28'h0, ls_codes[i], 2'b01});
            settle();
            `CHK(ls_spd, ls_codes[i])
        end
        i_partner.set_speed(LS_10M);
        wr32(IDX_IF_MODE, 32'h0000_0007);
        settle();
        `CHK(ls_spd, LS_10M)
        wr32(IDX_IF_MODE, 32'h0000_0004);
        settle();
        `CHK(ls_sel, 1'b0)
        `CHK(ls_spd, LS_1G)
        foreach (hs_codes[i]) begin
            wr32(IDX_CTRL, {27'h0, hs_codes[i], 2'b01});
            settle();
            `CHK(hs_spd, hs_codes[i])
        end
        `CHK(hs_sel, 1'b1)
        wr32(IDX_CTRL, 32'h0000_0014);
        settle();
        `CHK(hs_spd, HS_10G)
        wr32(IDX_CTRL, 32'hFFFF_FDE3);
        rd_chk(IDX_CTRL, 32'h0000_0003);
        `CHK(hs_spd, HS_10M)
        i_partner.set_link(1'b1);
        rd_chk(IDX_STATUS, 32'h0000_0000);
        rd_chk(IDX_STATUS, 32'h0000_0004);
        i_partner.set_link(1'b0);
        i_partner.set_link(1'b1);
        rd_chk(IDX_STATUS, 32'h0000_0000);
        rd_chk(IDX_STATUS, 32'h0000_0004);
        i_partner.send_word(W_A);
        i_partner.send_word(W_A);
        rd_chk(IDX_PARTNER, 32'h0000_0000);
        i_partner.send_word(W_A);
        rd_chk(IDX_PARTNER, {16'h0, (W_A & PA_KEEP_MASK) | 16'h4000});
        `CHK(hs_spd, HS_2G5)
        foreach (seq[i]) i_partner.send_word(seq[i]);
        rd_chk(IDX_PARTNER, {16'h0, (W_A & PA_KEEP_MASK) | 16'h4000});
        i_partner.send_word(W_B);
        i_partner.send_word(W_B);
        rd_chk(IDX_PARTNER, {16'h0, (W_B & PA_KEEP_MASK) | 16'h4000});
        `CHK(hs_spd, HS_10G)
        i_partner.pulse_done();
        rd_chk(IDX_STATUS, 32'h0000_0024);
        rd_chk(IDX_IRQ_STAT, 32'h0000_0007);
        `CHK(irq, 1'b0)
        wr32(IDX_IRQ_EN, 32'h0000_0002);
        settle();
        `CHK(irq, 1'b1)
        wr32(IDX_IRQ_CLEAR, 32'h0000_0002, 4'h1);
        settle();
        `CHK(irq, 1'b0)
        rd_chk(IDX_IRQ_STAT, 32'h0000_0005);
        rd_chk(IDX_IRQ_EN, 32'h0000_0002);
        rd_chk(IDX_IRQ_CLEAR, 32'h0000_0000);
        wr32(IDX_IRQ_CLEAR, 32'h0000_0007, 4'h1);
        rd_chk(IDX_IRQ_STAT, 32'h0000_0000);
        // restart bit sits in lane 1, so a lane 0 write must not fire it
        wr32(IDX_CTRL, 32'h0000_0203, 4'h1);
        settle();
        `CHK(n_rst, 8'h00)
        wr32(IDX_CTRL, 32'h0000_0203, 4'h3);
        settle();
        `CHK(n_rst, 8'h01)
        rd_chk(IDX_CTRL, 32'h0000_0003);
        rd_chk(IDX_STATUS, 32'h0000_0004);
        rd_chk(IDX_PARTNER, 32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
